/* dv/bas_sva.sv */
`timescale 1ns/1ns
module bas_sva
   import bas_pkg::*;
(
   input wire logic       aclk,
   input wire logic       aresetn,
   input wire logic       sclk,
   input wire logic       power_down_n,
   input wire logic       ready_and_serial_out,
   input wire logic [2:0] mode,
   input wire logic       cal_active,
   input wire logic       cal_armed
);
   localparam int WAKE_MAX = 1200;
   int lo_q;
   int hi_q;
   int wk_q;
   // ----------------------------------------
   // Run lengths of pin levels
   // ----------------------------------------
   always_ff @(posedge aclk) begin
      lo_q <= (!aresetn || power_down_n) ? 0 : lo_q + 1;
      hi_q <= (!aresetn || !sclk) ? 0 : hi_q + 1;
      // Wake is longer than a delay range may reach
      wk_q <= (aresetn && power_down_n && (mode == D_PDN || mode == D_WAKE)) ? wk_q + 1 : 0;
   end
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   pdn_line_a: assert property (!power_down_n [*8] |-> ready_and_serial_out && mode == D_PDN)
      else $error("device active in power-down");
   pdn_reset_a: assert property (!power_down_n [*8] |-> !cal_armed && !cal_active)
      else $error("state kept in power-down");
   pup_low_a: assert property ($rose(aresetn) |-> !power_down_n)
      else $error("power-down released at reset");
   pdn_width_a: assert property ($rose(power_down_n) |-> lo_q >= N_POWER_DOWN_N - 1)
      else $error("power-down pulse too short");
   pdn_sclk_a: assert property (!power_down_n |-> !sclk)
      else $error("shift clock high in power-down");
   wake_time_a: assert property (wk_q <= WAKE_MAX)
      else $error("no wake after release");
   stby_line_a: assert property (mode == D_STBY |-> ready_and_serial_out)
      else $error("line low in standby");
   stby_entry_a: assert property ($rose(mode == D_STBY) |-> sclk && hi_q >= (N_STBY - 1) * N_INT_DIV)
      else $error("standby entered early");
   cal_line_a: assert property (cal_active |-> ready_and_serial_out)
      else $error("line low during calibration");
   sclk_width_a: assert property ($fell(sclk) && power_down_n |-> hi_q >= N_HALF)
      else $error("shift pulse too short");
   cover property ($rose(cal_active));
   cover property ($rose(mode == D_STBY));
   cover property ($rose(power_down_n));
   cover property ($fell(ready_and_serial_out));
endmodule : bas_sva

/* dv/tb_bridge_adc_standby_powerdown.sv */
`timescale 1ns/1ns
module tb_bridge_adc_standby_powerdown;
   import bas_pkg::*;
   localparam int SC_F = 200, SC_S = 300, CAL_F = 150, CAL_S = 250, S_F = 100, S_S = 160;
   logic        aclk = 1'b0, aresetn = 1'b0, speed_fast = 1'b1, ca, line;
   logic        ext_clk = 1'b0, ext_on = 1'b0;
   logic [19:0] sample = 20'hA5C3B;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_q;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
   logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic [2:0]  mode;
   logic        ext_clock, cal_active, cal_armed;
   int          n_errors = 0, checks = 0, n;
   int          exp_t [4] = '{SC_F, SC_S, S_F, S_S};
   // ----------------------------------------
   // Both ends on one link
   // ----------------------------------------
   bas_link_if bas_link_if_inst ();
   assign bas_link_if_inst.clock_source_pin = ext_clk & ext_on;
   assign line = bas_link_if_inst.ready_and_serial_out;
   bas_dev #(.P_SC_FAST(SC_F), .P_SC_SLOW(SC_S), .P_CAL_FAST(CAL_F), .P_CAL_SLOW(CAL_S),
      .P_S_FAST(S_F), .P_S_SLOW(S_S), .P_CONV_FAST(140), .P_CONV_SLOW(160)) bas_dev_inst (
      .aclk, .aresetn, .link(bas_link_if_inst), .speed_fast, .sample, .mode, .ext_clock,
      .cal_active, .cal_armed);
   bas_host bas_host_inst (.aclk, .aresetn, .link(bas_link_if_inst), .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq);
   bas_sva bas_sva_inst (.aclk, .aresetn, .sclk(bas_link_if_inst.sclk),
      .power_down_n(bas_link_if_inst.power_down_n), .ready_and_serial_out(line), .mode,
      .cal_active, .cal_armed);
   always #4 aclk = ~aclk;
   always #40 ext_clk = ~ext_clk;
   // ----------------------------------------
   // Bus and check tasks
   // ----------------------------------------
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      resp = s_axi_rresp;
      rd_q = s_axi_rdata;
      s_axi_rready <= 1'b0;
   endtask : rd
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         n_errors++;
         $display("unexpected %s: expected %h, seen %h", nm, e, g);
      end
   endtask : chk
   task automatic wait_done();
      do rd(REG_STAT);
      while (rd_q[EV_DONE] !== 1'b1);
   endtask : wait_done
   task automatic read_chk();
      wr(REG_STAT, 32'h3);
      wr(REG_CMD, {29'h0, CMD_READ});
      wait_done();
      rd(REG_DATA);
      chk("data", {12'h0, sample}, rd_q);
   endtask : read_chk
   task automatic pwr(input logic on);
      wr(REG_CTRL, {31'h0, on});
      while (mode !== (on ? D_RUN : D_PDN)) @(posedge aclk);
   endtask : pwr
   task automatic span();
      n = 0;
      while (line !== 1'b0) begin
         @(posedge aclk);
         n++;
         if (n == 50) ca = cal_active;
      end
   endtask : span
   task automatic finish_test();
      $display("checks %0d, n_errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : finish_test
   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial begin
      #1_200_000;
      n_errors++;
      finish_test();
   end
   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      chk("pdn at reset", 0, bas_link_if_inst.power_down_n);
      chk("mode off", D_PDN, mode);
      rd(8'h20);
      chk("unmapped rresp", RESP_ERR, resp);
      chk("unmapped rdata", 0, rd_q);
      wr(8'h20, 32'h0);
      chk("unmapped bresp", RESP_ERR, resp);
      rd(REG_CTRL);
      chk("ctrl reset", 0, rd_q);
      wr(REG_CTRL, 32'h1);
      while (bas_link_if_inst.power_down_n !== 1'b1) @(posedge aclk);
      ca = 1'b0;
      span();
      pwr(1'b1);
      chk("clock source", 0, ext_clock);
      wr(REG_MASK, 32'h0);
      wr(REG_CMD, {29'h0, CMD_READ});
      wait_done();
      chk("irq masked", 0, irq);
      wr(REG_MASK, 32'h1);
      chk("irq raised", 1, irq);
      rd(REG_DATA);
      chk("data", {12'h0, sample}, rd_q);
      wr(REG_STAT, 32'h1);
      chk("irq cleared", 0, irq);
      // Calibrating and plain standby, both rates
      for (int k = 0; k < 4; k++) begin
         speed_fast <= !k[0];
         wr(REG_CMD, k < 2 ? {29'h0, CMD_STBY_CAL} : {29'h0, CMD_STBY});
         while (mode !== D_STBY) @(posedge aclk);
         chk("armed", k < 2, cal_armed);
         sample <= 20'h5A000 + 20'(k);
         wr(REG_CMD, {29'h0, CMD_WAKE});
         ca = 1'b0;
         span();
         chk("calibrating", k < 2, ca);
         chk("ready delay", 1, n > exp_t[k] * N_INT_DIV - 40 && n < exp_t[k] * N_INT_DIV + 60);
         read_chk();
      end
      wr(REG_CMD, {29'h0, CMD_CAL});
      while (cal_active !== 1'b1) @(posedge aclk);
      span();
      chk("cal delay", 1, n > CAL_S * N_INT_DIV - 40 && n < CAL_S * N_INT_DIV + 60);
      wr(REG_CMD, {29'h0, CMD_STBY_CAL});
      while (mode !== D_STBY) @(posedge aclk);
      pwr(1'b0);
      chk("arm cleared", 0, cal_armed);
      pwr(1'b1);
      wr(REG_CMD, {29'h0, CMD_READ});
      repeat (10) @(posedge bas_link_if_inst.sclk);
      pwr(1'b0);
      chk("line off", 1, line);
      pwr(1'b1);
      read_chk();
      ext_on <= 1'b1;
      repeat (40) @(posedge aclk);
      chk("clock source ext", 1, ext_clock);
      read_chk();
      finish_test();
   end
endmodule : tb_bridge_adc_standby_powerdown

/* hw/bas_dev.sv */
`timescale 1ns/1ns
// Function
// - Host: 25 pulses then hold high
// - Armed standby calibrates right after wake
// - Ready 103 or 803 ms after armed wake, 52.51 or 401.8 ms after plain wake
// - First result after calibration used directly
// - Power-down low holds everything off
// - Power-down resets all internal state except the pin synchronisers
// - Power-down accepted mid readback
// - Resume within wake time after release
// - Delays scale with modulator clock period
// - Internal oscillator unless external clock toggles
// - Host keeps power-down low at power-up
// - Line low on ready, MSB first out
// - Clock high 20 us enters standby
// - Falling 26th pulse starts calibration
module bas_dev
   import bas_pkg::*;
#(
   parameter int unsigned P_SC_FAST   = N_SC_FAST,
   parameter int unsigned P_SC_SLOW   = N_SC_SLOW,
   parameter int unsigned P_CAL_FAST  = N_CAL_FAST,
   parameter int unsigned P_CAL_SLOW  = N_CAL_SLOW,
   parameter int unsigned P_S_FAST    = N_S_FAST,
   parameter int unsigned P_S_SLOW    = N_S_SLOW,
   parameter int unsigned P_CONV_FAST = N_CONV_FAST,
   parameter int unsigned P_CONV_SLOW = N_CONV_SLOW
) (
   input  wire logic          aclk,
   input  wire logic          aresetn,
   bas_link_if.dev            link,
   input  wire logic          speed_fast,
   input  wire logic [19:0]   sample,
   output logic [2:0]         mode,
   output logic               ext_clock,
   output logic               cal_active,
   output logic               cal_armed
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      logic [2:0]    s1;
      logic [2:0]    s2;
      logic [2:0]    s3;
      logic [2:0]    flt;
      bas_dst_t      st;
      logic [CW-1:0] cnt;
      logic [CW-1:0] tgt;
      logic [6:0]    hi;
      logic [4:0]    div;
      logic [6:0]    loss;
      logic          ext;
      logic [4:0]    nsh;
      logic [19:0]   sh;
      logic          rdy;
      logic          out;
      logic          armed;
      logic          cal;
   } bas_dev_t;

   localparam bas_dev_t DEV_RST = '{st: D_PDN, out: 1'b1, default: '0};

   bas_dev_t q;
   bas_dev_t d;

   logic          sclk_rise;
   logic          sclk_fall;
   logic          ext_rise;
   logic          tick;
   logic [CW-1:0] conv_n;
   logic [CW-1:0] wake_n;
   logic [4:0]    nsh_n;

   always_comb begin
      d = q;
      // Bit 0 shift clock, 1 power-down, 2 clock pin
      d.s1 = {link.clock_source_pin, link.power_down_n, link.sclk};
      d.s2 = q.s1;
      d.s3 = q.s2;
      d.flt = (q.s2 & q.s3) | (q.flt & (q.s2 ^ q.s3));
      sclk_rise = d.flt[0] & ~q.flt[0];
      sclk_fall = ~d.flt[0] & q.flt[0];
      ext_rise = d.flt[2] & ~q.flt[2];

      // ----------------------------------------
      // Time base
      // ----------------------------------------
      // Pin tied low never toggles, so the loss count saturates
      if (ext_rise) begin
         d.loss = '0;
         d.ext = 1'b1;
      end else if (q.loss == 7'(N_EXT_LOSS - 1)) begin
         d.ext = 1'b0;
      end else begin
         d.loss = q.loss + 7'h01;
      end
      d.div = (q.div == 5'(N_INT_DIV - 1)) ? 5'h00 : q.div + 5'h01;
      // All delays count ticks, so they track the clock period
      tick = q.ext ? ext_rise : (q.div == 5'(N_INT_DIV - 1));
      conv_n = speed_fast ? CW'(P_CONV_FAST) : CW'(P_CONV_SLOW);
      wake_n = q.ext ? CW'(N_WAKE_EXT) : CW'(N_WAKE_INT);
      nsh_n = (q.nsh == 5'h1F) ? q.nsh : q.nsh + 5'h01;

      // ----------------------------------------
      // Sequencer
      // ----------------------------------------
      case (q.st)
         D_PDN: begin
            if (q.flt[1]) begin
               d.st = D_WAKE;
               d.cnt = '0;
            end
         end
         D_WAKE: begin
            if (tick) begin
               d.cnt = q.cnt + CW'(1);
               if (q.cnt >= wake_n - CW'(1)) begin
                  d.st = D_RUN;
                  d.cnt = '0;
               end
            end
         end
         D_RUN: begin
            if (tick) begin
               d.cnt = q.cnt + CW'(1);
            end
            if (tick && q.cnt >= conv_n - CW'(1)) begin
               // Unread data is simply overwritten
               d.cnt = '0;
               d.sh = sample;
               d.rdy = 1'b1;
               d.nsh = '0;
               d.out = 1'b0;
               d.hi = '0;
            end else if (q.rdy) begin
               if (sclk_rise) begin
                  d.nsh = nsh_n;
                  if (nsh_n <= 5'(RES_BITS)) begin
                     d.out = q.sh[5'(RES_BITS) - nsh_n];
                  end else begin
                     d.out = 1'b1;
                  end
               end
               if (sclk_fall && q.nsh == 5'(N_CAL_EDGE)) begin
                  d.st = D_SETTLE;
                  d.cnt = '0;
                  d.cal = 1'b1;
                  d.out = 1'b1;
                  d.tgt = speed_fast ? CW'(P_CAL_FAST) : CW'(P_CAL_SLOW);
               end else if (!q.flt[0]) begin
                  d.hi = '0;
               end else if (tick) begin
                  d.hi = q.hi + 7'h01;
                  if (q.hi >= 7'(N_STBY - 1)) begin
                     d.st = D_STBY;
                     d.out = 1'b1;
                     d.armed = (q.nsh == 5'(N_ARM));
                  end
               end
            end
         end
         D_STBY: begin
            if (!q.flt[0]) begin
               d.st = D_SETTLE;
               d.cnt = '0;
               d.armed = 1'b0;
               d.cal = q.armed;
               if (q.armed) begin
                  d.tgt = speed_fast ? CW'(P_SC_FAST) : CW'(P_SC_SLOW);
               end else begin
                  d.tgt = speed_fast ? CW'(P_S_FAST) : CW'(P_S_SLOW);
               end
            end
         end
         D_SETTLE: begin
            if (tick) begin
               d.cnt = q.cnt + CW'(1);
               if (q.cnt >= q.tgt - CW'(1)) begin
                  // Settled result goes straight out
                  d.st = D_RUN;
                  d.cnt = '0;
                  d.cal = 1'b0;
                  d.sh = sample;
                  d.rdy = 1'b1;
                  d.nsh = '0;
                  d.hi = '0;
                  d.out = 1'b0;
               end
            end
         end
         default: begin
            d.st = D_PDN;
         end
      endcase

      // ----------------------------------------
      // Power-down
      // ----------------------------------------
      // Mid-readback too; only the pin synchronisers survive
      if (!q.flt[1]) begin
         d = DEV_RST;
         d.s1 = {link.clock_source_pin, link.power_down_n, link.sclk};
         d.s2 = q.s1;
         d.s3 = q.s2;
         d.flt = (q.s2 & q.s3) | (q.flt & (q.s2 ^ q.s3));
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= DEV_RST;
      end else begin
         q <= d;
      end
   end

   assign link.ready_and_serial_out = q.out;
   assign mode = q.st;
   assign ext_clock = q.ext;
   assign cal_active = q.cal;
   assign cal_armed = q.armed;
endmodule : bas_dev

/* hw/bas_host.sv */
// Design decisions made here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ns
module bas_host
   import bas_pkg::*;
(
   input  wire logic          aclk,
   input  wire logic          aresetn,
   bas_link_if.host           link,
   input  wire logic [7:0]    s_axi_awaddr,
   input  wire logic          s_axi_awvalid,
   output logic               s_axi_awready,
   input  wire logic [31:0]   s_axi_wdata,
   input  wire logic [3:0]    s_axi_wstrb,
   input  wire logic          s_axi_wvalid,
   output logic               s_axi_wready,
   output logic [1:0]         s_axi_bresp,
   output logic               s_axi_bvalid,
   input  wire logic          s_axi_bready,
   input  wire logic [7:0]    s_axi_araddr,
   input  wire logic          s_axi_arvalid,
   output logic               s_axi_arready,
   output logic [31:0]        s_axi_rdata,
   output logic [1:0]         s_axi_rresp,
   output logic               s_axi_rvalid,
   input  wire logic          s_axi_rready,
   output logic               irq
);
   typedef struct packed {
      logic          s1;
      logic          s2;
      logic          s3;
      logic          flt;
      logic          aw_ok;
      logic          w_ok;
      logic [7:0]    awaddr;
      logic [31:0]   wdata;
      logic [3:0]    wstrb;
      logic          bvalid;
      logic [1:0]    bresp;
      logic          rvalid;
      logic [31:0]   rdata;
      logic [1:0]    rresp;
      logic          pwr;
      logic [19:0]   data;
      logic [1:0]    stat;
      logic [1:0]    mask;
      bas_hst_t      st;
      logic [4:0]    npl;
      logic [4:0]    pcnt;
      logic          hold;
      logic [3:0]    div;
      logic          sclk;
      logic          pdn;
      logic [11:0]   pw;
   } bas_host_t;

   bas_host_t q;
   bas_host_t d;
   logic [1:0] ev;

   function automatic logic [2:0] reg_idx(logic [7:0] a);
      case (a)
         REG_CTRL: return 3'h0;
         REG_CMD:  return 3'h1;
         REG_DATA: return 3'h2;
         REG_STAT: return 3'h3;
         REG_MASK: return 3'h4;
         default:  return 3'h7;
      endcase
   endfunction : reg_idx

   always_comb begin
      d = q;
      ev = '0;
      d.s1 = link.ready_and_serial_out;
      d.s2 = q.s1;
      d.s3 = q.s2;
      if (q.s2 == q.s3) begin
         d.flt = q.s2;
      end
      if (q.flt && !d.flt && (q.st == H_IDLE || q.st == H_WAIT)) begin
         ev[EV_RDY] = 1'b1;
      end

      // ----------------------------------------
      // Link sequencer
      // ----------------------------------------
      case (q.st)
         H_OFF: begin
            // Enforce the minimum low pulse before release
            if (q.pw != 12'(N_POWER_DOWN_N)) begin
               d.pw = q.pw + 12'h001;
            end else if (q.pwr) begin
               d.pdn = 1'b1;
               d.st = H_IDLE;
            end
         end
         H_WAIT: begin
            if (!q.flt) begin
               d.sclk = 1'b1;
               d.div = '0;
               d.pcnt = 5'h01;
               d.st = (q.npl == 5'h00) ? H_HOLD : H_HI;
               ev[EV_DONE] = (q.npl == 5'h00);
            end
         end
         H_HI: begin
            d.div = q.div + 4'h1;
            if (q.div == 4'(N_HALF - 1)) begin
               d.div = '0;
               if (q.pcnt <= 5'(RES_BITS)) begin
                  d.data = {q.data[18:0], q.flt};
               end
               if (q.pcnt == q.npl && q.hold) begin
                  d.st = H_HOLD;
                  ev[EV_DONE] = 1'b1;
               end else begin
                  d.sclk = 1'b0;
                  d.st = H_LO;
               end
            end
         end
         H_LO: begin
            d.div = q.div + 4'h1;
            if (q.div == 4'(N_HALF - 1)) begin
               d.div = '0;
               if (q.pcnt == q.npl) begin
                  d.st = H_IDLE;
                  ev[EV_DONE] = 1'b1;
               end else begin
                  d.sclk = 1'b1;
                  d.pcnt = q.pcnt + 5'h01;
                  d.st = H_HI;
               end
            end
         end
         default: begin
         end
      endcase

      // ----------------------------------------
      // Register bus
      // ----------------------------------------
      if (s_axi_awvalid && s_axi_awready) begin
         d.aw_ok = 1'b1;
         d.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         d.w_ok = 1'b1;
         d.wdata = s_axi_wdata;
         d.wstrb = s_axi_wstrb;
      end
      if (q.bvalid && s_axi_bready) begin
         d.bvalid = 1'b0;
      end
      if (q.aw_ok && q.w_ok && !q.bvalid) begin
         d.aw_ok = 1'b0;
         d.w_ok = 1'b0;
         d.bvalid = 1'b1;
         d.bresp = RESP_OK;
         case (reg_idx(q.awaddr))
            3'h0: begin
               if (q.wstrb[0]) begin
                  d.pwr = q.wdata[CTRL_PWR];
               end
            end
            3'h1: begin
               // Commands while busy are dropped
               if (q.wstrb[0] && q.st == H_HOLD && q.wdata[2:0] == CMD_WAKE) begin
                  d.sclk = 1'b0;
                  d.st = H_IDLE;
               end else if (q.wstrb[0] && q.st == H_IDLE) begin
                  d.hold = 1'b0;
                  d.st = H_WAIT;
                  case (q.wdata[2:0])
                     CMD_READ: d.npl = 5'(N_READ);
                     CMD_CAL:  d.npl = 5'(N_CAL_EDGE);
                     CMD_STBY: begin
                        d.npl = 5'h00;
                        d.hold = 1'b1;
                     end
                     CMD_STBY_CAL: begin
                        d.npl = 5'(N_ARM);
                        d.hold = 1'b1;
                     end
                     default: d.st = H_IDLE;
                  endcase
               end
            end
            3'h2: begin
            end
            3'h3: begin
               if (q.wstrb[0]) begin
                  d.stat = q.stat & ~q.wdata[1:0];
               end
            end
            3'h4: begin
               if (q.wstrb[0]) begin
                  d.mask = q.wdata[1:0];
               end
            end
            default: d.bresp = RESP_ERR;
         endcase
      end
      // Set after clear so a new event is never lost
      d.stat = d.stat | ev;

      if (q.rvalid && s_axi_rready) begin
         d.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         d.rvalid = 1'b1;
         d.rresp = RESP_OK;
         d.rdata = '0;
         case (reg_idx(s_axi_araddr))
            3'h0: d.rdata[CTRL_PWR] = q.pwr;
            3'h1: d.rdata[3:0] = {q.pdn, q.st};
            3'h2: d.rdata[19:0] = q.data;
            3'h3: d.rdata[1:0] = q.stat;
            3'h4: d.rdata[1:0] = q.mask;
            default: d.rresp = RESP_ERR;
         endcase
      end

      // Power-down wins at any point of a transfer
      if (!d.pwr && q.st != H_OFF) begin
         d.pdn = 1'b0;
         d.sclk = 1'b0;
         d.pw = '0;
         d.st = H_OFF;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign s_axi_awready = !q.aw_ok && !q.bvalid;
   assign s_axi_wready = !q.w_ok && !q.bvalid;
   assign s_axi_bvalid = q.bvalid;
   assign s_axi_bresp = q.bresp;
   assign s_axi_arready = !q.rvalid;
   assign s_axi_rvalid = q.rvalid;
   assign s_axi_rdata = q.rdata;
   assign s_axi_rresp = q.rresp;
   assign irq = |(q.stat & q.mask);
   assign link.sclk = q.sclk;
   assign link.power_down_n = q.pdn;
endmodule : bas_host

/* hw/bas_link_if.sv */
`timescale 1ns/1ns
interface bas_link_if;
   logic sclk;
   logic power_down_n;
   logic ready_and_serial_out;
   logic clock_source_pin;

   modport dev (
      input  sclk,
      input  power_down_n,
      input  clock_source_pin,
      output ready_and_serial_out
   );
   modport host (
      output sclk,
      output power_down_n,
      input  ready_and_serial_out
   );
endinterface : bas_link_if

/* hw/bas_pkg.sv */
package bas_pkg;
   // ----------------------------------------
   // Clock rates
   // ----------------------------------------
   localparam longint F_ACLK_HZ = 125_000_000;
   localparam longint F_MOD_HZ  = 4_915_200;
   localparam longint NS_PER_S  = 1_000_000_000;

   function automatic longint ceil_n(longint t_ns, longint f_hz);
      longint n;
      n = (t_ns * f_hz + NS_PER_S - 1) / NS_PER_S;
      return (n < 1) ? 1 : n;
   endfunction : ceil_n

   function automatic longint floor_n(longint t_ns, longint f_hz);
      longint n;
      n = (t_ns * f_hz) / NS_PER_S;
      return (n < 1) ? 1 : n;
   endfunction : floor_n

   // ----------------------------------------
   // Device times, counted in modulator ticks
   // ----------------------------------------
   localparam longint T_SC_FAST_NS  = 103_000_000;
   localparam longint T_SC_SLOW_NS  = 803_000_000;
   localparam longint T_CAL_FAST_NS = 101_280_000;
   localparam longint T_CAL_SLOW_NS = 801_020_000;
   localparam longint T_S_FAST_NS   = 52_510_000;
   localparam longint T_S_SLOW_NS   = 401_800_000;
   localparam longint T_CONV_FAST_NS = 12_500_000;
   localparam longint T_CONV_SLOW_NS = 100_000_000;
   localparam longint T_STBY_NS     = 20_000;
   localparam longint T_WAKE_INT_NS = 7_950;
   localparam longint T_WAKE_EXT_NS = 160;
   localparam int N_SC_FAST  = int'(ceil_n(T_SC_FAST_NS, F_MOD_HZ));
   localparam int N_SC_SLOW  = int'(ceil_n(T_SC_SLOW_NS, F_MOD_HZ));
   localparam int N_CAL_FAST = int'(ceil_n(T_CAL_FAST_NS, F_MOD_HZ));
   localparam int N_CAL_SLOW = int'(ceil_n(T_CAL_SLOW_NS, F_MOD_HZ));
   localparam int N_S_FAST   = int'(ceil_n(T_S_FAST_NS, F_MOD_HZ));
   localparam int N_S_SLOW   = int'(ceil_n(T_S_SLOW_NS, F_MOD_HZ));
   localparam int N_CONV_FAST = int'(ceil_n(T_CONV_FAST_NS, F_MOD_HZ));
   localparam int N_CONV_SLOW = int'(ceil_n(T_CONV_SLOW_NS, F_MOD_HZ));
   localparam int N_STBY     = int'(ceil_n(T_STBY_NS, F_MOD_HZ));
   localparam int N_WAKE_INT = int'(floor_n(T_WAKE_INT_NS, F_MOD_HZ));
   localparam int N_WAKE_EXT = int'(floor_n(T_WAKE_EXT_NS, F_MOD_HZ));
   localparam int N_INT_DIV  = int'((F_ACLK_HZ + F_MOD_HZ - 1) / F_MOD_HZ);
   localparam int N_EXT_LOSS = 64;
   localparam int CW         = 23;

   // ----------------------------------------
   // Host times, counted in aclk cycles
   // ----------------------------------------
   localparam longint T_SCLK_NS = 100;
   localparam longint T_POWER_DOWN_N_NS = 26_000;
   localparam int N_HALF = int'(ceil_n(T_SCLK_NS, F_ACLK_HZ));
   localparam int N_POWER_DOWN_N = int'(ceil_n(T_POWER_DOWN_N_NS, F_ACLK_HZ));

   // ----------------------------------------
   // Serial frame
   // ----------------------------------------
   localparam int RES_BITS   = 20;
   localparam int N_PAD_END  = 24;
   localparam int N_ARM      = 25;
   localparam int N_CAL_EDGE = 26;
   localparam int N_READ     = 21;

   // ----------------------------------------
   // Host registers
   // ----------------------------------------
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_CMD  = 8'h04;
   localparam logic [7:0] REG_DATA = 8'h08;
   localparam logic [7:0] REG_STAT = 8'h0C;
   localparam logic [7:0] REG_MASK = 8'h10;
   localparam int CTRL_PWR = 0;
   localparam int EV_DONE  = 0;
   localparam int EV_RDY   = 1;
   localparam logic [1:0] RESP_OK  = 2'h0;
   localparam logic [1:0] RESP_ERR = 2'h2;

   typedef enum logic [2:0] {
      CMD_NONE = 3'h0, CMD_READ = 3'h1, CMD_CAL = 3'h2,
      CMD_STBY = 3'h3, CMD_STBY_CAL = 3'h4, CMD_WAKE = 3'h5
   } bas_cmd_t;

   typedef enum logic [2:0] {
      D_PDN = 3'h0, D_WAKE = 3'h1, D_RUN = 3'h2,
      D_STBY = 3'h3, D_SETTLE = 3'h4
   } bas_dst_t;

   typedef enum logic [2:0] {
      H_OFF = 3'h0, H_IDLE = 3'h1, H_WAIT = 3'h2,
      H_HI = 3'h3, H_LO = 3'h4, H_HOLD = 3'h5
   } bas_hst_t;
endpackage : bas_pkg
